/* File: bench/sfspi_core_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sfspi_core_chk #(
  parameter int unsigned SR_CYCLES = 4
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SERIAL_IN,
  input wire logic HOLD_N,
  input wire logic WP_N,
  input wire logic SO,
  input wire logic SO_OE,
  input wire logic WRITE_IN_PROGRESS,
  input wire logic WRITE_ENABLE_LATCH
);
  // The shortest internal cycle is a status write of four enabled clocks.
  sequence s_busy_min;
    WRITE_IN_PROGRESS [*4];
  endsequence
  sequence s_paused;
    !HOLD_N ##1 !HOLD_N;
  endsequence
  AST_DESEL: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    CS_N |-> !SO_OE) else $error("output driven while deselected");
  AST_RST: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(NRST) |-> !WRITE_ENABLE_LATCH && !WRITE_IN_PROGRESS)
    else $error("latch or busy set after reset");
  AST_NEEDWEL: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(WRITE_IN_PROGRESS) |-> $past(WRITE_ENABLE_LATCH))
    else $error("cycle started without write enable");
  AST_AFTERCS: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(WRITE_IN_PROGRESS) |-> $past(CS_N))
    else $error("cycle started while selected");
  AST_WELCLR: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $fell(WRITE_IN_PROGRESS) |-> ##[0:1] !WRITE_ENABLE_LATCH)
    else $error("latch kept after cycle end");
  AST_BUSYMIN: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(WRITE_IN_PROGRESS) |-> s_busy_min)
    else $error("busy shorter than shortest cycle");
  AST_WELIDLE: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(WRITE_ENABLE_LATCH) |-> !$past(WRITE_IN_PROGRESS))
    else $error("latch set while busy");
  AST_PAUSE: assert property (@(negedge SCK) disable iff (!NRST)
    s_paused |-> !SO_OE) else $error("output driven while paused");
endmodule // sfspi_core_chk
`default_nettype wire

/* File: bench/sfspi_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfspi_host (
  output logic sck,
  output logic cs_n,
  output logic serial_in,
  output logic hold_n,
  input wire logic so
);
  logic [7:0] buf_q [0:259];
  // Chip select starts low, as a frame left open at power-up.
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    serial_in = 1'b0;
    hold_n = 1'b1;
  end
  task automatic frame(input int nb, input int xb, input bit m3,
                       input int hold_at, output logic [7:0] rx);
    int i;
    int k;
    rx = 8'h00;
    sck = m3;
    #7 cs_n = 1'b0;
    for (i = 0; i < nb * 8 + xb; i++) begin
      sck = 1'b0;
      serial_in = buf_q[i / 8][7 - i % 8];
      if (i == hold_at) begin
        #5 hold_n = 1'b0;
        for (k = 0; k < 5; k++) #15 sck = ~sck;
        // Released while high, so driving resumes at the next falling edge.
        #5 hold_n = 1'b1;
        #10 sck = 1'b0;
      end
      #15 sck = 1'b1;
      rx = {rx[6:0], so};
      #15;
    end
    sck = m3;
    #7 cs_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule // sfspi_host
`default_nettype wire

/* File: bench/tb_serial_flash_spi_core.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_spi_core;
  import sfspi_pkg::*;
  localparam int unsigned SRC = 4;
  logic clk, nrst, ce, wp_n, so, so_oe, write_in_progress, write_enable_latch;
  wire logic sck, cs_n, sdi, hold_n, so_w;
  logic [15:0] lfsr_q = 16'h28DD;
  logic [7:0] st;
  logic [23:0] a;
  int mismatches = 0;
  int checks_done = 0;
  int run_n = 0;
  int last_n = 0;
  int i, k;
  // A floating output shows a pattern that changes every half clock.
  assign so_w = so_oe ? so : ~sck;
  sfspi_core #(.BOOT_TOP(1'b0), .SR_CYCLES(SRC)) i_dut (
    .SYS_CLK(clk), .NRST(nrst), .CE(ce), .SCK(sck), .CS_N(cs_n),
    .SERIAL_IN(sdi), .HOLD_N(hold_n), .WP_N(wp_n), .SO(so),
    .SO_OE(so_oe), .WRITE_IN_PROGRESS(write_in_progress), .WRITE_ENABLE_LATCH(write_enable_latch));
  sfspi_host i_host (.sck(sck), .cs_n(cs_n), .serial_in(sdi),
    .hold_n(hold_n), .so(so_w));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (write_in_progress === 1'b1) begin
      run_n <= run_n + 1;
    end else if (run_n != 0) begin
      last_n <= run_n;
      run_n <= 0;
    end
  end
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0],
              lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  function automatic int exp_len(input logic [23:0] ad);
    if (ad[19:0] < BOT_S2_BASE) return SIZE_4K;
    if (ad[19:0] < BOT_S3_BASE) return SIZE_8K;
    if (ad[19:0] < BOT_S4_BASE) return SIZE_16K;
    if (ad[19:0] < BOT_S5_BASE) return SIZE_32K;
    return SIZE_64K;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", nm, want, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] ad,
                     input int nb, input int xb);
    logic [7:0] rx;
    i_host.buf_q[0] = op;
    {i_host.buf_q[1], i_host.buf_q[2], i_host.buf_q[3]} = ad;
    @(negedge clk);
    i_host.frame(nb, xb, rnd() > 16'h7FFF, -1, rx);
    repeat (10) @(negedge clk);
  endtask
  task automatic rdsr(output logic [7:0] sv);
    i_host.buf_q[0] = CMD_STATUS_READ;
    @(negedge clk);
    i_host.frame(2, 0, rnd() > 16'h7FFF, 10, sv);
    repeat (10) @(negedge clk);
  endtask
  task automatic idle(input bit rce);
    int g;
    g = 0;
    while ((write_in_progress !== 1'b0 || run_n != 0) && g < 40000) begin
      @(negedge clk);
      ce = rce ? rnd() > 16'h3FFF : 1'h1;
      g++;
    end
    if (g >= 40000) mismatches++;
    @(negedge clk);
    ce = 1'h1;
  endtask
  initial begin
    nrst = 1'h0;
    ce = 1'h1;
    wp_n = 1'h1;
    repeat (3) @(negedge clk);
    nrst = 1'h1;
    cmd(CMD_WRITE_ENABLE, 24'h00_0000, 1, 0);
    check("wel", write_enable_latch, 1'h0);
    check("wip", write_in_progress, 1'h0);
    $display("test power-up done");
    cmd(CMD_WRITE_ENABLE, 24'h00_0000, 1, 0);
    check("wel", write_enable_latch, 1'h1);
    rdsr(st);
    check("status", st, 8'h02);
    cmd(CMD_WRITE_DISABLE, 24'h00_0000, 1, 0);
    check("wel", write_enable_latch, 1'h0);
    cmd(CMD_SECTOR_ERASE, 24'h00_0000, 4, 0);
    check("wip", write_in_progress, 1'h0);
    cmd(CMD_BULK_ERASE, 24'h00_0000, 1, 0);
    check("wip", write_in_progress, 1'h0);
    cmd(CMD_WRITE_ENABLE, 24'h00_0000, 1, 0);
    cmd(CMD_PAGE_PROGRAM, 24'h00_0000, 5, 3);
    check("wip", write_in_progress, 1'h0);
    check("wel", write_enable_latch, 1'h1);
    $display("test latch done");
    for (k = 0; k < 2; k++) begin
      for (i = 4; i < 260; i++) begin
        i_host.buf_q[i] = 8'(rnd());
      end
      a = {8'h00, rnd()};
      cmd(CMD_WRITE_ENABLE, a, 1, 0);
      cmd(CMD_PAGE_PROGRAM, a, k ? 5 + int'(rnd() % 255) : 260, 0);
      rdsr(st);
      check("status", st, 8'h03);
      idle(k);
      if (k == 0) check("prog", last_n, PAGE_BYTES);
      check("wel", write_enable_latch, 1'h0);
    end
    $display("test program done");
    cmd(CMD_WRITE_ENABLE, a, 1, 0);
    cmd(CMD_STATUS_WRITE, 24'h80_0000, 2, 0);
    idle(0);
    check("srw", last_n, SRC);
    wp_n = 1'h0;
    cmd(CMD_WRITE_ENABLE, a, 1, 0);
    cmd(CMD_STATUS_WRITE, 24'h00_0000, 2, 0);
    check("wip", write_in_progress, 1'h0);
    rdsr(st);
    check("status", st, 8'h82);
    wp_n = 1'h1;
    cmd(CMD_STATUS_WRITE, 24'h00_0000, 2, 0);
    idle(0);
    rdsr(st);
    check("status", st, 8'h00);
    $display("test status done");
    cmd(CMD_WRITE_ENABLE, a, 1, 0);
    check("wel", write_enable_latch, 1'h1);
    nrst = 1'h0;
    repeat (3) @(negedge clk);
    nrst = 1'h1;
    repeat (4) @(negedge clk);
    check("wel", write_enable_latch, 1'h0);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      a = (k == 0 ? 24'h00_0000 : 24'h00_0800 << k) | 24'(rnd() & 16'h0FFF);
      cmd(CMD_WRITE_ENABLE, a, 1, 0);
      cmd(CMD_SECTOR_ERASE, a, 4, 0);
      idle(0);
      check("erase", last_n, exp_len(a));
    end
    $display("test erase done");
    close_out();
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule // tb_serial_flash_spi_core
bind sfspi_core sfspi_core_chk #(.SR_CYCLES(SR_CYCLES)) i_chk (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .CE(CE), .SCK(SCK), .CS_N(CS_N),
  .SERIAL_IN(SERIAL_IN), .HOLD_N(HOLD_N), .WP_N(WP_N), .SO(SO),
  .SO_OE(SO_OE), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS),
  .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH));
`default_nettype wire

/* File: hdl/sfspi_core.sv */
`timescale 1ns/1ps
`default_nettype none
module sfspi_core #(
  parameter bit BOOT_TOP = 1'b0,
  parameter int unsigned SR_CYCLES = sfspi_pkg::SR_WRITE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SERIAL_IN,
  input wire logic HOLD_N,
  input wire logic WP_N,
  output logic SO,
  output logic SO_OE,
  output logic WRITE_IN_PROGRESS,
  output logic WRITE_ENABLE_LATCH
);
  import sfspi_pkg::*;

  sfspi_link_if lnk ();

  sfspi_link u_link (
    .sck(SCK),
    .cs_n(CS_N),
    .nrst(NRST),
    .serial_in(SERIAL_IN),
    .hold_n(HOLD_N),
    .lnk(lnk.link),
    .so(SO),
    .so_oe(SO_OE)
  );

  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic al_s1_q;
  logic al_s2_q;
  logic wp_s1_q;
  logic wp_s2_q;
  logic armed_q;
  logic in_frame_q;
  logic end_q;
  logic [2:0] nb_q;
  logic [7:0] dcnt_q;
  logic [7:0] opc_q;
  logic [23:0] addr_q;
  logic [7:0] sr_val_q;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] mem [MEM_BYTES];
  sfspi_seq_t state_q;
  logic [19:0] ptr_q;
  logic [19:0] last_q;
  logic [7:0] wcnt_q;
  logic wel_q;
  logic wip_q;
  logic srp_q;
  logic [2:0] bp_q;
  logic cs_fall;
  logic cs_rise;
  logic byte_ev;
  logic [19:0] a20;
  logic [19:0] sec_sz;
  logic [19:0] sec_base;
  logic [19:0] page_base;
  logic mem_we;
  logic [7:0] mem_wd;
  logic [7:0] status;

  // Boot layout is fixed at build time through BOOT_TOP.
  function automatic logic [19:0] sector_size(input logic [19:0] a);
    if (BOOT_TOP) begin
      if (a >= TOP_S10_BASE) begin
        sector_size = SIZE_4K;
      end else if (a >= TOP_S9_BASE) begin
        sector_size = SIZE_8K;
      end else if (a >= TOP_S8_BASE) begin
        sector_size = SIZE_16K;
      end else if (a >= TOP_S7_BASE) begin
        sector_size = SIZE_32K;
      end else begin
        sector_size = SIZE_64K;
      end
    end else begin
      if (a < BOT_S2_BASE) begin
        sector_size = SIZE_4K;
      end else if (a < BOT_S3_BASE) begin
        sector_size = SIZE_8K;
      end else if (a < BOT_S4_BASE) begin
        sector_size = SIZE_16K;
      end else if (a < BOT_S5_BASE) begin
        sector_size = SIZE_32K;
      end else begin
        sector_size = SIZE_64K;
      end
    end
  endfunction

  function automatic logic [19:0] prot_size(input logic [2:0] bp);
    unique case (bp)
      3'd0: prot_size = 20'h0_0000;
      3'd1: prot_size = SIZE_4K;
      3'd2: prot_size = SIZE_8K;
      3'd3: prot_size = SIZE_16K;
      3'd4: prot_size = SIZE_32K;
      3'd5: prot_size = SIZE_64K;
      3'd6: prot_size = SIZE_256K;
      3'd7: prot_size = MEM_TOTAL;
    endcase
  endfunction

  // Protected region grows from the boot end of the array.
  function automatic logic is_prot(input logic [19:0] a, input logic [2:0] bp);
    if (BOOT_TOP) begin
      is_prot = (a >= (MEM_TOTAL - prot_size(bp)));
    end else begin
      is_prot = (a < prot_size(bp));
    end
  endfunction

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cs_s1_q <= 1'b0;
      cs_s2_q <= 1'b0;
      cs_s3_q <= 1'b0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      al_s1_q <= 1'b0;
      al_s2_q <= 1'b0;
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
    end else if (CE) begin
      cs_s1_q <= CS_N;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      tgl_s1_q <= lnk.rx_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      al_s1_q <= lnk.aligned;
      al_s2_q <= al_s1_q;
      wp_s1_q <= WP_N;
      wp_s2_q <= wp_s1_q;
    end
  end

  assign cs_fall = cs_s3_q && !cs_s2_q;
  assign cs_rise = cs_s2_q && !cs_s3_q;
  assign byte_ev = tgl_s2_q ^ tgl_s3_q;

  // Frame tracking and command byte collection.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      armed_q <= 1'b0;
      in_frame_q <= 1'b0;
      end_q <= 1'b0;
      nb_q <= 3'd0;
      dcnt_q <= 8'h00;
      opc_q <= 8'h00;
      addr_q <= 24'h00_0000;
      sr_val_q <= STATUS_RST;
    end else if (CE) begin
      if (cs_s2_q) begin
        armed_q <= 1'b1;
      end
      end_q <= cs_rise && in_frame_q;
      if (cs_fall && armed_q) begin
        in_frame_q <= 1'b1;
        nb_q <= 3'd0;
        dcnt_q <= 8'h00;
      end else if (byte_ev && in_frame_q) begin
        if (nb_q == 3'd0) begin
          opc_q <= lnk.rx_byte;
        end else if (nb_q < 3'd4) begin
          addr_q <= {addr_q[15:0], lnk.rx_byte};
        end else begin
          dcnt_q <= dcnt_q + 8'd1;
        end
        if (nb_q == 3'd1) begin
          sr_val_q <= lnk.rx_byte;
        end
        if (nb_q != 3'd5) begin
          nb_q <= nb_q + 3'd1;
        end
      end
      // The last byte may arrive in the same cycle as the frame end.
      if (cs_rise) begin
        in_frame_q <= 1'b0;
      end
    end
  end

  // Page buffer starts erased so bytes not sent leave the array unchanged.
  always_ff @(posedge SYS_CLK) begin
    if (CE && state_q == SQ_IDLE) begin
      if (cs_fall && armed_q) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
          pbuf[i] <= ERASED_BYTE;
        end
      end else if (byte_ev && in_frame_q && nb_q >= 3'd4) begin
        pbuf[8'(addr_q[7:0] + dcnt_q)] <= lnk.rx_byte;
      end
    end
  end

  assign a20 = {1'b0, addr_q[ADDR_W-1:0]};
  assign sec_sz = sector_size(a20);
  assign sec_base = a20 & ~(sec_sz - 20'd1);
  assign page_base = {a20[19:8], 8'h00};

  // Internal cycles run on the system clock, independent of chip select.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= SQ_IDLE;
      ptr_q <= 20'h0_0000;
      last_q <= 20'h0_0000;
      wcnt_q <= 8'h00;
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      srp_q <= 1'b0;
      bp_q <= 3'd0;
    end else if (CE) begin
      unique case (state_q)
        SQ_IDLE: begin
          if (end_q && al_s2_q) begin
            if (opc_q == CMD_WRITE_ENABLE) begin
              wel_q <= 1'b1;
            end else if (opc_q == CMD_WRITE_DISABLE) begin
              wel_q <= 1'b0;
            end else if (opc_q == CMD_STATUS_WRITE && nb_q >= 3'd2 &&
                         wel_q && !(srp_q && !wp_s2_q)) begin
              state_q <= SQ_SRW;
              wcnt_q <= 8'h00;
              wip_q <= 1'b1;
            end else if (opc_q == CMD_PAGE_PROGRAM && nb_q == 3'd5 &&
                         wel_q && !is_prot(page_base, bp_q)) begin
              state_q <= SQ_PROG;
              ptr_q <= page_base;
              last_q <= page_base + 20'd255;
              wip_q <= 1'b1;
            end else if (opc_q == CMD_SECTOR_ERASE && nb_q >= 3'd4 &&
                         wel_q && !is_prot(sec_base, bp_q)) begin
              state_q <= SQ_ERASE;
              ptr_q <= sec_base;
              last_q <= sec_base + sec_sz - 20'd1;
              wip_q <= 1'b1;
            end else if (opc_q == CMD_BULK_ERASE && wel_q &&
                         bp_q == 3'd0) begin
              state_q <= SQ_ERASE;
              ptr_q <= 20'h0_0000;
              last_q <= MEM_TOTAL - 20'd1;
              wip_q <= 1'b1;
            end
          end
        end
        SQ_SRW: begin
          wcnt_q <= wcnt_q + 8'd1;
          if (wcnt_q == 8'(SR_CYCLES - 1)) begin
            bp_q <= sr_val_q[ST_BP_LO +: 3];
            srp_q <= sr_val_q[ST_SRP];
            wel_q <= 1'b0;
            wip_q <= 1'b0;
            state_q <= SQ_IDLE;
          end
        end
        SQ_PROG, SQ_ERASE: begin
          ptr_q <= ptr_q + 20'd1;
          if (ptr_q == last_q) begin
            wel_q <= 1'b0;
            wip_q <= 1'b0;
            state_q <= SQ_IDLE;
          end
        end
        default: begin
          state_q <= SQ_IDLE;
        end
      endcase
    end
  end

  assign mem_we = (state_q == SQ_PROG) || (state_q == SQ_ERASE);
  always_comb begin
    if (state_q == SQ_PROG) begin
      mem_wd = mem[ptr_q[ADDR_W-1:0]] & pbuf[ptr_q[7:0]];
    end else begin
      mem_wd = ERASED_BYTE;
    end
  end

  // Array storage; only the sequencer writes it, one byte per cycle.
  always_ff @(posedge SYS_CLK) begin
    if (CE && mem_we) begin
      mem[ptr_q[ADDR_W-1:0]] <= mem_wd;
    end
  end

  always_comb begin
    status = STATUS_RST;
    status[ST_WIP] = wip_q;
    status[ST_WEL] = wel_q;
    status[ST_BP_LO +: 3] = bp_q;
    status[ST_SRP] = srp_q;
  end
  assign lnk.status = status;

  assign WRITE_IN_PROGRESS = wip_q;
  assign WRITE_ENABLE_LATCH = wel_q;
endmodule // sfspi_core
`default_nettype wire

/* File: hdl/sfspi_link.sv */
`timescale 1ns/1ps
`default_nettype none
module sfspi_link (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic nrst,
  input wire logic serial_in,
  input wire logic hold_n,
  sfspi_link_if.link lnk,
  output logic so,
  output logic so_oe
);
  import sfspi_pkg::*;

  logic [2:0] cnt_q;
  logic [6:0] shift_q;
  logic first_q;
  logic [7:0] opcode_q;
  logic [7:0] out_byte_q;
  logic [7:0] stat_s1_q;
  logic [7:0] stat_s2_q;
  logic [7:0] byte_q;
  logic tgl_q;
  logic aligned_q;

  // Bit position and opcode restart with every selection.
  always_ff @(posedge sck or posedge cs_n or negedge nrst) begin
    if (!nrst || cs_n) begin
      cnt_q <= 3'd0;
      shift_q <= 7'd0;
      first_q <= 1'b1;
      opcode_q <= 8'h00;
      out_byte_q <= STATUS_RST;
    end else if (hold_n) begin
      shift_q <= {shift_q[5:0], serial_in};
      cnt_q <= cnt_q + 3'd1;
      if (cnt_q == 3'd7) begin
        first_q <= 1'b0;
        out_byte_q <= stat_s2_q;
        if (first_q) begin
          opcode_q <= {shift_q, serial_in};
        end
      end
    end
  end

  // Byte handoff survives deselection so the core can judge the frame.
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      byte_q <= 8'h00;
      tgl_q <= 1'b0;
      aligned_q <= 1'b0;
    end else if (!cs_n && hold_n) begin
      aligned_q <= (cnt_q == 3'd7);
      if (cnt_q == 3'd7) begin
        byte_q <= {shift_q, serial_in};
        tgl_q <= ~tgl_q;
      end
    end
  end

  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      stat_s1_q <= STATUS_RST;
      stat_s2_q <= STATUS_RST;
    end else begin
      stat_s1_q <= lnk.status;
      stat_s2_q <= stat_s1_q;
    end
  end

  // Output flops float the pin whenever deselected, and from the next falling clock edge once paused.
  always_ff @(negedge sck or posedge cs_n or negedge nrst) begin
    if (!nrst || cs_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_oe <= hold_n && !first_q && (opcode_q == CMD_STATUS_READ);
      so <= out_byte_q[~cnt_q];
    end
  end

  assign lnk.rx_byte = byte_q;
  assign lnk.rx_tgl = tgl_q;
  assign lnk.aligned = aligned_q;
endmodule // sfspi_link
`default_nettype wire

/* File: hdl/sfspi_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sfspi_link_if;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic aligned;
  logic [7:0] status;
  modport link (output rx_byte, output rx_tgl, output aligned, input status);
  modport core (input rx_byte, input rx_tgl, input aligned, output status);
endinterface // sfspi_link_if
`default_nettype wire

/* File: hdl/sfspi_pkg.sv */
package sfspi_pkg;
  // Contract
  // - Serial input bits are sampled on each rising serial clock edge while selected.
  // - Serial output bits change on each falling serial clock edge.
  // - Chip select high deselects the device and floats the serial output.
  // - After reset no instruction counts until chip select has fallen from high.
  // - Pause low while selected floats output and ignores serial input and clock; the output floats only from the next falling clock edge.
  // - Write protect pin blocks status writes only while SRP is set; protect bits guard array regions.
  // - Array holds 524,288 bytes as 2048 pages of 256 bytes, linear.
  // - Programming only clears bits; erase by sector or whole array, never page.
  // - Bottom layout: 4K, 4K, 8K at 02000h, 16K, 32K, then 64K sectors.
  // - Top layout: 64K sectors, 32K at 70000h, 16K, 8K at 7C000h, 4K, 4K.
  // - Works in clock modes 0 and 3; sample rising, drive falling.
  // - One program command takes up to 256 bytes within a single page.
  // - Sector erase sets its sector to FFh; bulk erase sets every byte.
  // - Erase runs only after a preceding write enable command.
  // - Status exposes write in progress during status write, program or erase.
  // - A running internal cycle completes even after chip select returns high.
  // - Write enable latch clears at reset and when modifying commands complete.
  // - Modifying commands execute only when the frame's clock count is whole bytes.
  // - Pause starts and ends only while the serial clock is low; the bench host ends it while the clock is high.

  localparam int unsigned MEM_BYTES = 524288;
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned PAGE_BYTES = 256;
  localparam logic [19:0] MEM_TOTAL = 20'h8_0000;

  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] CMD_BULK_ERASE = 8'hC7;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam int unsigned ST_WIP = 0;
  localparam int unsigned ST_WEL = 1;
  localparam int unsigned ST_BP_LO = 2;
  localparam int unsigned ST_SRP = 7;

  localparam int unsigned SR_WRITE_CYCLES = 64;

  localparam logic [19:0] SIZE_4K = 20'h0_1000;
  localparam logic [19:0] SIZE_8K = 20'h0_2000;
  localparam logic [19:0] SIZE_16K = 20'h0_4000;
  localparam logic [19:0] SIZE_32K = 20'h0_8000;
  localparam logic [19:0] SIZE_64K = 20'h1_0000;
  localparam logic [19:0] SIZE_256K = 20'h4_0000;

  localparam logic [19:0] BOT_S2_BASE = 20'h0_2000;
  localparam logic [19:0] BOT_S3_BASE = 20'h0_4000;
  localparam logic [19:0] BOT_S4_BASE = 20'h0_8000;
  localparam logic [19:0] BOT_S5_BASE = 20'h1_0000;
  localparam logic [19:0] TOP_S7_BASE = 20'h7_0000;
  localparam logic [19:0] TOP_S8_BASE = 20'h7_8000;
  localparam logic [19:0] TOP_S9_BASE = 20'h7_C000;
  localparam logic [19:0] TOP_S10_BASE = 20'h7_E000;

  typedef enum logic [3:0] {
    SQ_IDLE = 4'b0001,
    SQ_SRW = 4'b0010,
    SQ_PROG = 4'b0100,
    SQ_ERASE = 4'b1000
  } sfspi_seq_t;
endpackage
